// >>> rtl/mci_defs.vh
// Shared constants of the card start-up command block
`ifndef MCI_DEFS_VH
`define MCI_DEFS_VH
// Register byte offsets
`define MCI_REG_CTRL 8'h00
`define MCI_REG_WIN 8'h04
`define MCI_REG_STAT 8'h08
`define MCI_REG_CID0 8'h0c
`define MCI_REG_CID1 8'h10
`define MCI_REG_CID2 8'h14
`define MCI_REG_CID3 8'h18
// Control fields and reset values
`define MCI_CTRL_VHS_LSB 0
`define MCI_CTRL_HICAP 4
`define MCI_CTRL_LVSUP 5
`define MCI_CTRL_EN 6
`define MCI_CTRL_PWRCYC 7
`define MCI_CTRL_RST 7'h71
`define MCI_WIN_RST 16'hff80
`define MCI_CID_RST 32'h0
// Command and reply indices
`define MCI_CMD_RESET 6'h00
`define MCI_CMD_IDREQ 6'h02
`define MCI_CMD_ADDR 6'h03
`define MCI_CMD_IFCOND 6'h08
`define MCI_CMD_APP 6'h37
`define MCI_CMD_OPCOND 6'h29
`define MCI_RSP_OCR_IDX 6'h3f
// Argument and reply bit positions
`define MCI_ARG_BUSY 31
`define MCI_ARG_HCS 30
`define MCI_ARG_XPC 28
`define MCI_ARG_LVR 24
`define MCI_STAT_APP 5
// Timing
`define MCI_CLK_KHZ 20000
`define MCI_INIT_LIMIT_MS 1000
`define MCI_INIT_CYC (`MCI_INIT_LIMIT_MS * `MCI_CLK_KHZ)
`define MCI_NCR_EDGES 3'd2
`endif

// >>> rtl/mci_cmd_rx.v
// Command frame receiver: 48 bits, checks framing and CRC7
`timescale 1ns/100ps
module mci_cmd_rx (
    input wire clk_i,
    input wire rst_i,
    input wire en_i,
    input wire bit_en_i,
    input wire bit_i,
    output reg vld_o,
    output reg ok_o,
    output reg [5:0] idx_o,
    output reg [31:0] arg_o
);
    reg [47:0] sh_q;
    reg [5:0] cnt_q;
    reg [6:0] crc;
    integer i;

    // CRC7 over the first 40 bits of the frame
    always @* begin
        crc = 7'h00;
        for (i = 47; i >= 8; i = i - 1) begin
            crc = {crc[5:0], 1'b0} ^ ((sh_q[i] ^ crc[6]) ? 7'h09 : 7'h00);
        end
    end

    // Start bit opens a frame, the 48th bit closes it
    always @(posedge clk_i) begin
        vld_o <= 1'b0;
        if (rst_i | ~en_i) begin
            cnt_q <= 6'h00;
            sh_q <= 48'h0;
            ok_o <= 1'b0;
            idx_o <= 6'h00;
            arg_o <= 32'h0;
        end else if (cnt_q == 6'd48) begin
            cnt_q <= 6'h00;
            vld_o <= 1'b1;
            ok_o <= ~sh_q[46] ? 1'b0 : (sh_q[0] & (crc == sh_q[7:1]));
            idx_o <= sh_q[45:40];
            arg_o <= sh_q[39:8];
        end else if (bit_en_i && (cnt_q != 6'h00 || !bit_i)) begin
            sh_q <= {sh_q[46:0], bit_i};
            cnt_q <= cnt_q + 6'd1;
        end
    end
endmodule // mci_cmd_rx

// >>> rtl/mci_rsp_tx.v
// Reply serialiser: 48-bit replies or 136-bit identity reply
`timescale 1ns/100ps
`include "mci_defs.vh"
module mci_rsp_tx (
    input wire clk_i,
    input wire rst_i,
    input wire start_i,
    input wire long_i,
    input wire crc_en_i,
    input wire [39:0] data_i,
    input wire [127:0] cid_i,
    input wire bit_en_i,
    output reg bit_o,
    output reg oe_o,
    output wire busy_o
);
    reg [135:0] sh_q;
    reg [7:0] n_q;
    reg [6:0] crc;
    integer i;

    // CRC7 of the 40 leading bits of a short reply
    always @* begin
        crc = 7'h00;
        for (i = 39; i >= 0; i = i - 1) begin
            crc = {crc[5:0], 1'b0} ^ ((data_i[i] ^ crc[6]) ? 7'h09 : 7'h00);
        end
    end

    assign busy_o = oe_o | (n_q != 8'h00);

    // Bits change on falling link edges so the host samples them stable
    always @(posedge clk_i) begin
        if (rst_i) begin
            sh_q <= 136'h0;
            n_q <= 8'h00;
            bit_o <= 1'b1;
            oe_o <= 1'b0;
        end else if (start_i) begin
            if (long_i) begin
                sh_q <= {2'b00, `MCI_RSP_OCR_IDX, cid_i[127:1], 1'b1};
                n_q <= 8'd136;
            end else begin
                sh_q <= {data_i, (crc_en_i ? crc : 7'h7f), 1'b1, 88'h0};
                n_q <= 8'd48;
            end
        end else if (bit_en_i) begin
            if (n_q != 8'h00) begin
                bit_o <= sh_q[135];
                oe_o <= 1'b1;
                sh_q <= {sh_q[134:0], 1'b0};
                n_q <= n_q - 8'd1;
            end else begin
                bit_o <= 1'b1;
                oe_o <= 1'b0;
            end
        end
    end
endmodule // mci_rsp_tx

// >>> rtl/mci_card.v
// Card start-up command interpreter with its Wishbone register file
//
// Implementation choices: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
`include "mci_defs.vh"
module mci_card #(
    parameter INIT_CYCLES = `MCI_INIT_CYC
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire sclk_i,
    input wire cmd_i,
    output wire cmd_o,
    output wire cmd_oe_o
);
    localparam [4:0] ST_IDLE = 5'b00001;
    localparam [4:0] ST_READY = 5'b00010;
    localparam [4:0] ST_IDENT = 5'b00100;
    localparam [4:0] ST_STBY = 5'b01000;
    localparam [4:0] ST_INACT = 5'b10000;
    localparam [31:0] INIT_LAST_W = INIT_CYCLES - 1;
    // Counter is 25 bits wide, enough for one second at 20 MHz
    localparam [24:0] INIT_LAST = INIT_LAST_W[24:0];

    reg [4:0] state_q;
    reg [6:0] ctrl_q;
    reg [15:0] win_q;
    reg [127:0] cid_q;
    reg pwr_cyc_q;
    reg [15:0] rca_q;
    reg [15:0] lfsr_q;
    reg app_q;
    reg ifok_q;
    reg init_q;
    reg done_q;
    reg hcs_q;
    reg xpc_q;
    reg lvr_q;
    reg [24:0] init_cnt_q;
    reg rsp_req_q;
    reg rsp_long_q;
    reg rsp_crc_q;
    reg [39:0] rsp_data_q;
    reg pend_q;
    reg [2:0] ncr_q;
    reg tx_go_q;
    reg sclk_m_q;
    reg sclk_s_q;
    reg sclk_p_q;
    reg cmd_m_q;
    reg cmd_s_q;
    reg [3:0] st_code;
    reg [31:0] ocr_word;
    reg [31:0] card_stat;
    reg [31:0] wmask;
    reg [31:0] rd_d;
    wire sclk_rise;
    wire sclk_fall;
    wire rx_vld;
    wire rx_ok;
    wire [5:0] rx_idx;
    wire [31:0] rx_arg;
    wire tx_busy;
    wire wb_req;
    wire wr_en;
    wire [3:0] supplied_voltage_field;
    wire vhs_onehot;
    wire cap_block;

    // Two-stage synchronisers; the first stage feeds no logic, and a third sclk stage feeds the edge detect
    always @(posedge clk_i) begin
        if (rst_i) begin
            sclk_m_q <= 1'b0;
            sclk_s_q <= 1'b0;
            sclk_p_q <= 1'b0;
            cmd_m_q <= 1'b1;
            cmd_s_q <= 1'b1;
        end else begin
            sclk_m_q <= sclk_i;
            sclk_s_q <= sclk_m_q;
            sclk_p_q <= sclk_s_q;
            cmd_m_q <= cmd_i;
            cmd_s_q <= cmd_m_q;
        end
    end
    assign sclk_rise = sclk_s_q & ~sclk_p_q;
    assign sclk_fall = ~sclk_s_q & sclk_p_q;

    // Receiver is held off while a reply is pending or on the line
    mci_cmd_rx u_rx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(~pend_q & ~tx_busy & ~tx_go_q & ~rsp_req_q),
        .bit_en_i(sclk_rise),
        .bit_i(cmd_s_q),
        .vld_o(rx_vld),
        .ok_o(rx_ok),
        .idx_o(rx_idx),
        .arg_o(rx_arg)
    );

    mci_rsp_tx u_tx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(tx_go_q),
        .long_i(rsp_long_q),
        .crc_en_i(rsp_crc_q),
        .data_i(rsp_data_q),
        .cid_i(cid_q),
        .bit_en_i(sclk_fall),
        .bit_o(cmd_o),
        .oe_o(cmd_oe_o),
        .busy_o(tx_busy)
    );

    // Reply gap: a fixed number of falling edges after the end bit
    always @(posedge clk_i) begin
        tx_go_q <= 1'b0;
        if (rst_i) begin
            pend_q <= 1'b0;
            ncr_q <= 3'h0;
        end else if (rsp_req_q) begin
            pend_q <= 1'b1;
            ncr_q <= 3'h0;
        end else if (pend_q && sclk_fall) begin
            if (ncr_q == `MCI_NCR_EDGES - 3'd1) begin
                pend_q <= 1'b0;
                tx_go_q <= 1'b1;
            end else begin
                ncr_q <= ncr_q + 3'd1;
            end
        end
    end

    // Free-running address source, never zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            lfsr_q <= 16'h0001;
        end else begin
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[14] ^ lfsr_q[12] ^ lfsr_q[3]};
        end
    end

    // Reply words built from the live card state
    assign supplied_voltage_field = rx_arg[11:8];
    assign vhs_onehot = (supplied_voltage_field != 4'h0) && ((supplied_voltage_field & (supplied_voltage_field - 4'h1)) == 4'h0);
    assign cap_block = ctrl_q[`MCI_CTRL_HICAP] & ~(ifok_q & hcs_q);
    always @* begin
        case (state_q)
            ST_READY: st_code = 4'h1;
            ST_IDENT: st_code = 4'h2;
            ST_STBY: st_code = 4'h3;
            default: st_code = 4'h0;
        endcase
        ocr_word = 32'h0;
        ocr_word[`MCI_ARG_BUSY] = done_q;
        ocr_word[`MCI_ARG_HCS] = done_q & ifok_q & ctrl_q[`MCI_CTRL_HICAP];
        ocr_word[`MCI_ARG_LVR] = done_q & lvr_q & ctrl_q[`MCI_CTRL_LVSUP];
        ocr_word[23:8] = win_q;
        card_stat = {19'h0, st_code, 9'h0};
        card_stat[`MCI_STAT_APP] = 1'b1;
    end

    // Command interpreter
    always @(posedge clk_i) begin
        rsp_req_q <= 1'b0;
        if (rst_i || pwr_cyc_q) begin
            state_q <= ST_IDLE;
            rca_q <= 16'h0;
            app_q <= 1'b0;
            ifok_q <= 1'b0;
            init_q <= 1'b0;
            done_q <= 1'b0;
            hcs_q <= 1'b0;
            xpc_q <= 1'b0;
            lvr_q <= 1'b0;
            init_cnt_q <= 25'h0;
            rsp_long_q <= 1'b0;
            rsp_crc_q <= 1'b1;
            rsp_data_q <= 40'h0;
        end else begin
            // Initialisation timer; stalls for a blocked capacity pairing
            if (init_q && !done_q && !cap_block) begin
                if (init_cnt_q == INIT_LAST) begin
                    done_q <= 1'b1;
                end else begin
                    init_cnt_q <= init_cnt_q + 25'd1;
                end
            end
            // Bad CRC or framing leaves everything untouched
            if (rx_vld && rx_ok && ctrl_q[`MCI_CTRL_EN] && state_q != ST_INACT) begin
                app_q <= 1'b0;
                rsp_long_q <= 1'b0;
                rsp_crc_q <= 1'b1;
                case (rx_idx)
                    `MCI_CMD_RESET: begin
                        state_q <= ST_IDLE;
                        rca_q <= 16'h0;
                        ifok_q <= 1'b0;
                        init_q <= 1'b0;
                        done_q <= 1'b0;
                        init_cnt_q <= 25'h0;
                    end
                    `MCI_CMD_IFCOND: begin
                        // Answer only an acceptable single voltage bit
                        if (state_q == ST_IDLE && vhs_onehot &&
                            (supplied_voltage_field & ctrl_q[3:0]) != 4'h0) begin
                            ifok_q <= 1'b1;
                            rsp_data_q <= {2'b00, `MCI_CMD_IFCOND, 20'h0, rx_arg[11:0]};
                            rsp_req_q <= 1'b1;
                        end
                    end
                    `MCI_CMD_APP: begin
                        if ((state_q == ST_IDLE || state_q == ST_STBY) &&
                            rx_arg[31:16] == rca_q) begin
                            app_q <= 1'b1;
                            rsp_data_q <= {2'b00, `MCI_CMD_APP, card_stat};
                            rsp_req_q <= 1'b1;
                        end
                    end
                    `MCI_CMD_OPCOND: begin
                        // Without the prefix this is an illegal command
                        if (app_q && state_q == ST_IDLE) begin
                            rsp_data_q <= {2'b00, `MCI_RSP_OCR_IDX, ocr_word};
                            rsp_crc_q <= 1'b0;
                            if (rx_arg[23:0] == 24'h0) begin
                                rsp_req_q <= 1'b1;
                            end else if (init_q) begin
                                // Repeats keep the first argument's effect
                                rsp_req_q <= 1'b1;
                                if (done_q) begin
                                    state_q <= ST_READY;
                                end
                            end else if ((rx_arg[23:8] & win_q) == 16'h0) begin
                                state_q <= ST_INACT;
                            end else begin
                                init_q <= 1'b1;
                                hcs_q <= rx_arg[`MCI_ARG_HCS];
                                xpc_q <= rx_arg[`MCI_ARG_XPC];
                                lvr_q <= rx_arg[`MCI_ARG_LVR];
                                rsp_req_q <= 1'b1;
                            end
                        end
                    end
                    `MCI_CMD_IDREQ: begin
                        if (state_q == ST_READY) begin
                            rsp_long_q <= 1'b1;
                            rsp_req_q <= 1'b1;
                            state_q <= ST_IDENT;
                        end
                    end
                    `MCI_CMD_ADDR: begin
                        if (state_q == ST_IDENT || state_q == ST_STBY) begin
                            rca_q <= lfsr_q;
                            rsp_data_q <= {2'b00, `MCI_CMD_ADDR, lfsr_q, 3'h0,
                                card_stat[12:0]};
                            rsp_req_q <= 1'b1;
                            state_q <= ST_STBY;
                        end
                    end
                    default: begin
                        rsp_req_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Wishbone classic slave: ack one cycle after the strobe, for one cycle
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_en = wb_req & wb_we_i;
    always @* begin
        wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        case (wb_adr_i)
            `MCI_REG_CTRL: rd_d = {25'h0, ctrl_q};
            `MCI_REG_WIN: rd_d = {16'h0, win_q};
            `MCI_REG_STAT: rd_d = {rca_q, 5'h0, init_q, lvr_q, xpc_q, hcs_q, ifok_q,
                done_q, state_q};
            `MCI_REG_CID0: rd_d = cid_q[31:0];
            `MCI_REG_CID1: rd_d = cid_q[63:32];
            `MCI_REG_CID2: rd_d = cid_q[95:64];
            `MCI_REG_CID3: rd_d = cid_q[127:96];
            default: rd_d = 32'h0;
        endcase
    end

    // Register writes; power-cycle bit is a self-clearing pulse
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            ctrl_q <= `MCI_CTRL_RST;
            win_q <= `MCI_WIN_RST;
            cid_q <= {4{`MCI_CID_RST}};
            pwr_cyc_q <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_d : 32'h0;
            pwr_cyc_q <= 1'b0;
            if (wr_en) begin
                case (wb_adr_i)
                    `MCI_REG_CTRL: begin
                        ctrl_q <= (ctrl_q & ~wmask[6:0]) | (wb_dat_i[6:0] & wmask[6:0]);
                        pwr_cyc_q <= wb_dat_i[`MCI_CTRL_PWRCYC] & wb_sel_i[0];
                    end
                    `MCI_REG_WIN: win_q <= (win_q & ~wmask[15:0]) |
                        (wb_dat_i[15:0] & wmask[15:0]);
                    `MCI_REG_CID0: cid_q[31:0] <= (cid_q[31:0] & ~wmask) | (wb_dat_i & wmask);
                    `MCI_REG_CID1: cid_q[63:32] <= (cid_q[63:32] & ~wmask) | (wb_dat_i & wmask);
                    `MCI_REG_CID2: cid_q[95:64] <= (cid_q[95:64] & ~wmask) | (wb_dat_i & wmask);
                    `MCI_REG_CID3: cid_q[127:96] <= (cid_q[127:96] & ~wmask) |
                        (wb_dat_i & wmask);
                    default: ctrl_q <= ctrl_q;
                endcase
            end
        end
    end
endmodule // mci_card

// >>> verification/mci_card_checker.sv
// Port-level assertion checker for the card start-up command block
`timescale 1ns/100ps
module mci_card_chk #(
    parameter INIT_CYCLES = 50
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire cmd_i,
    input wire cmd_o,
    input wire cmd_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Bus request not yet answered
    sequence wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // Card takes the command line for a reply
    sequence rsp_start;
        $rose(cmd_oe_o);
    endsequence
    ack_after_req_a: assert property (wb_req |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    read_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    reset_quiet_a: assert property ($fell(rst_i) |-> !wb_ack_o && !cmd_oe_o && cmd_o)
        else $error("outputs active right after reset");
    idle_high_a: assert property (!cmd_oe_o |-> cmd_o)
        else $error("drive value low while line released");
    start_bit_a: assert property (rsp_start |-> !cmd_o && $past(cmd_i))
        else $error("reply not opened by start bit on idle line");
    // Reply bits last a whole link period, so no change within six cycles
    bit_hold_a: assert property (cmd_oe_o && $changed(cmd_o) |=> $stable(cmd_o) [*6])
        else $error("reply bit changed too early");
    end_bit_a: assert property ($fell(cmd_oe_o) |-> $past(cmd_o) && cmd_o)
        else $error("reply not closed by end bit");
endmodule // mci_card_chk

bind mci_card mci_card_chk #(.INIT_CYCLES(INIT_CYCLES)) i_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cmd_i(cmd_i), .cmd_o(cmd_o), .cmd_oe_o(cmd_oe_o));

// >>> verification/mci_host_model.sv
// Host controller model: clocks out command frames and collects replies
`timescale 1ns/100ps
module mci_host_model (
    output reg sclk_o,
    output reg drv_o,
    output reg en_o,
    input wire line_i
);
    // Link clock stands low and the line is released between frames
    initial begin
        sclk_o = 1'b0;
        drv_o = 1'b1;
        en_o = 1'b0;
    end
    // Frame check code, x^7 + x^3 + 1, first bit first
    function [6:0] crc7(input [39:0] d);
        integer k;
        begin
            crc7 = 7'h00;
            for (k = 39; k >= 0; k = k - 1)
                crc7 = {crc7[5:0], 1'b0} ^ ((crc7[6] ^ d[k]) ? 7'h09 : 7'h00);
        end
    endfunction
    // One link period, line sampled at the rising edge
    task tick(output b);
        begin
            #200 sclk_o = 1'b1;
            b = line_i;
            #200 sclk_o = 1'b0;
        end
    endtask
    // Whole command frame, then a bounded wait for a reply of len bits
    task xfer(input [5:0] idx, input [31:0] arg, input bad, input integer len,
        output reg [135:0] rsp, output reg got);
        reg [47:0] f;
        reg b;
        integer k;
        begin
            f = {2'b01, idx, arg, crc7({2'b01, idx, arg}) ^ {6'h00, bad}, 1'b1};
            rsp = 136'h0;
            got = 1'b0;
            for (k = 47; k >= 0; k = k - 1) begin
                en_o = 1'b1;
                drv_o = f[k];
                tick(b);
            end
            en_o = 1'b0;
            drv_o = ~f[0];
            for (k = 0; k < 16 && !got; k = k + 1) begin
                tick(b);
                got = (b === 1'b0);
            end
            for (k = len - 2; got && k >= 0; k = k - 1) begin
                tick(b);
                rsp[k] = b;
            end
            // Quiet gap of eight link clocks before the next command
            repeat (8) tick(b);
        end
    endtask
endmodule // mci_host_model

// >>> verification/tb.sv
// Self-checking bench for the card start-up command block
`timescale 1ns/100ps
module tb;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg cyc = 1'b0;
    reg stb = 1'b0;
    reg we = 1'b0;
    reg [7:0] adr = 8'h00;
    reg [3:0] sel = 4'h0;
    reg [31:0] dwr = 32'h0;
    wire [31:0] dat;
    wire ack, sclk, hdrv, hen, card_o, card_oe;
    // Resolved command line with its pull-up
    wire line = card_oe ? card_o : (hen ? hdrv : 1'b1);
    integer bad_count, checks_done, seed, i, n;
    reg [127:0] card_identity_number;
    reg [135:0] rsp;
    reg got;
    reg [31:0] q, ifarg;
    reg [15:0] r1;
    reg [7:0] a;

    mci_card #(.INIT_CYCLES(50)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dwr),
        .wb_dat_o(dat), .wb_ack_o(ack), .sclk_i(sclk), .cmd_i(line), .cmd_o(card_o),
        .cmd_oe_o(card_oe));
    mci_host_model i_host (.sclk_o(sclk), .drv_o(hdrv), .en_o(hen), .line_i(line));

    always #25 clk_i = ~clk_i;

    task chk(input string nm, input [135:0] seen, input [135:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("FAIL %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // Classic single cycle, held until ack is sampled
    task wb(input w, input [7:0] ad, input [3:0] s, input [31:0] d);
        begin
            @(posedge clk_i);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= ad;
            sel <= s;
            dwr <= d;
            n = 0;
            @(posedge clk_i);
            while (ack !== 1'b1) begin
                @(posedge clk_i);
                n = n + 1;
            end
            q = dat;
            chk("wb_ack_delay", n, 1);
            cyc <= 1'b0;
            stb <= 1'b0;
        end
    endtask
    task rdchk(input string nm, input [7:0] ad, input [31:0] msk, input [31:0] exp);
        begin
            wb(1'b0, ad, 4'hf, 32'h0);
            chk(nm, q & msk, exp);
        end
    endtask
    // Link stimulus starts a fixed 13 ns after a clock edge, never on one
    task cmd(input [5:0] x, input [31:0] arg, input bad, input integer len);
        begin
            @(posedge clk_i);
            #13;
            i_host.xfer(x, arg, bad, len, rsp, got);
        end
    endtask
    task app_op(input [31:0] arg);
        begin
            cmd(6'h37, 32'h0, 1'b0, 48);
            cmd(6'h29, arg, 1'b0, 48);
        end
    endtask
    function [135:0] op_rsp(input b, input c, input s, input [15:0] w);
        op_rsp = {2'b00, 6'h3f, b, c, 1'b0, 4'h0, s, w, 8'h00, 7'h7f, 1'b1};
    endfunction
    function [135:0] if_rsp(input [31:0] arg);
        if_rsp = {2'b00, 6'h08, arg, i_host.crc7({2'b00, 6'h08, arg}), 1'b1};
    endfunction
    task conclude;
        begin
            if (bad_count == 0 && checks_done > 0) begin
                $display("Finished cleanly");
            end else begin
                $display("Finished with errors");
            end
            $finish;
        end
    endtask
    // Watchdog well beyond the expected run length
    initial begin
        #4000000;
        bad_count = bad_count + 1;
        conclude;
    end
    // Main sequence
    initial begin
        seed = 66991;
        bad_count = 0;
        checks_done = 0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("ctrl", 8'h00, 32'hff, 32'h71);
        rdchk("win", 8'h04, 32'hffff, 32'hff80);
        rdchk("state", 8'h08, 32'h1f, 32'h01);
        a = 8'h0c;
        for (i = 0; i < 4; i = i + 1) begin
            card_identity_number[i*32 +: 32] = $random(seed);
            wb(1'b1, a, 4'hf, card_identity_number[i*32 +: 32]);
            rdchk("cid", a, 32'hffffffff, card_identity_number[i*32 +: 32]);
            a = a + 8'h04;
        end
        // Single byte lane write leaves the other lanes alone
        wb(1'b1, 8'h18, 4'h1, ~card_identity_number[127:96]);
        card_identity_number[103:96] = ~card_identity_number[103:96];
        rdchk("cid_lane", 8'h18, 32'hffffffff, card_identity_number[127:96]);
        wb(1'b1, 8'h40, 4'hf, 32'hffffffff);
        rdchk("unmapped", 8'h40, 32'hffffffff, 32'h0);
        ifarg = {20'h0, 4'h1, 8'($random(seed))};
        // Unsupported supply, missing prefix, corrupt frame: all silent
        cmd(6'h08, {20'h0, 4'h2, ifarg[7:0]}, 1'b0, 48);
        chk("bad_supply", got, 0);
        rdchk("still_idle", 8'h08, 32'h1f, 32'h01);
        cmd(6'h29, 32'h00ff8000, 1'b0, 48);
        chk("no_prefix", got, 0);
        cmd(6'h08, ifarg, 1'b1, 48);
        chk("bad_crc", got, 0);
        cmd(6'h08, ifarg, 1'b0, 48);
        chk("if_echo", rsp, if_rsp(ifarg));
        app_op(32'h40000000);
        chk("inquiry", rsp, op_rsp(1'b0, 1'b0, 1'b0, 16'hff80));
        rdchk("no_init", 8'h08, 32'h400, 32'h0);
        // First real request, then retries with the same argument
        app_op(32'h51008000);
        chk("busy_first", rsp[39], 0);
        for (i = 0; i < 10 && rsp[39] !== 1'b1; i = i + 1)
            app_op(32'h51008000);
        chk("ready", rsp, op_rsp(1'b1, 1'b1, 1'b1, 16'hff80));
        rdchk("latched", 8'h08, 32'h3ff, 32'h3e2);
        cmd(6'h02, 32'h0, 1'b0, 136);
        chk("identity", rsp, {2'b00, 6'h3f, card_identity_number[127:1], 1'b1});
        rdchk("ident", 8'h08, 32'h1f, 32'h04);
        cmd(6'h03, 32'h0, 1'b0, 48);
        r1 = rsp[39:24];
        cmd(6'h03, 32'h0, 1'b0, 48);
        chk("fresh_addr", r1 == rsp[39:24], 0);
        rdchk("standby", 8'h08, 32'hffff001f, {rsp[39:24], 16'h0008});
        cmd(6'h00, 32'h0, 1'b0, 48);
        chk("reset_quiet", got, 0);
        rdchk("reset_idle", 8'h08, 32'hffff001f, 32'h01);
        // Capacity flag clear on a high capacity card: never ready
        cmd(6'h08, ifarg, 1'b0, 48);
        for (i = 0; i < 3; i = i + 1)
            app_op(32'h00008000);
        chk("never_ready", rsp[39], 0);
        // Window outside the card range, then reset cannot revive it
        cmd(6'h00, 32'h0, 1'b0, 48);
        cmd(6'h08, ifarg, 1'b0, 48);
        app_op(32'h00000100);
        chk("out_of_range", got, 0);
        rdchk("inactive", 8'h08, 32'h1f, 32'h10);
        cmd(6'h00, 32'h0, 1'b0, 48);
        rdchk("stays_inactive", 8'h08, 32'h1f, 32'h10);
        wb(1'b1, 8'h00, 4'hf, 32'hf1);
        rdchk("power_cycle", 8'h08, 32'h1f, 32'h01);
        // Disabled card ignores everything
        wb(1'b1, 8'h00, 4'hf, 32'h31);
        cmd(6'h08, ifarg, 1'b0, 48);
        chk("disabled", got, 0);
        // Standard capacity card without low-voltage support
        wb(1'b1, 8'h00, 4'hf, 32'h41);
        cmd(6'h08, ifarg, 1'b0, 48);
        app_op(32'h01008000);
        app_op(32'h01008000);
        chk("std_ready", rsp, op_rsp(1'b1, 1'b0, 1'b0, 16'hff80));
        conclude;
    end
endmodule // tb
